// file: pcs_pkg.sv
/*
  Constants for the peripheral clock source selection block: register
  offsets, field positions, reset values, source codes and unlock bytes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pcs_pkg;

  // register map, byte addresses
  localparam logic [11:0] PCS_ADDR_SEL    = 12'h0014;
  localparam logic [11:0] PCS_ADDR_UNLOCK = 12'h0100;

  localparam logic [31:0] PCS_SEL_RESET   = 32'hFFFF_FFFF;
  // bits that hold a source field; everything else is reserved
  localparam logic [31:0] PCS_FIELD_MASK  = 32'h0377_771F;
  localparam logic [31:0] PCS_WDT_MASK    = 32'h0000_0003;

  // field positions (low bit)
  localparam int PCS_UART_LSB = 24;
  localparam int PCS_TMR3_LSB = 20;
  localparam int PCS_TMR2_LSB = 16;
  localparam int PCS_TMR1_LSB = 12;
  localparam int PCS_TMR0_LSB = 8;
  localparam int PCS_SPI_BIT  = 4;
  localparam int PCS_ADC_LSB  = 2;
  localparam int PCS_WDT_LSB  = 0;

  // two-bit source codes (uart, adc, watchdog)
  localparam logic [1:0] PCS_S2_XTAL = 2'h0;
  localparam logic [1:0] PCS_S2_PLL  = 2'h1;
  localparam logic [1:0] PCS_S2_BUS  = 2'h2;
  localparam logic [1:0] PCS_S2_FRC  = 2'h3;
  localparam logic [1:0] PCS_WDT_DIV = 2'h2;
  localparam logic [1:0] PCS_WDT_SRC = 2'h3;

  // three-bit timer source codes
  localparam logic [2:0] PCS_T_XTAL = 3'h0;
  localparam logic [2:0] PCS_T_BUS  = 3'h2;
  localparam logic [2:0] PCS_T_TRIG = 3'h3;
  localparam logic [2:0] PCS_T_SRC  = 3'h5;
  localparam logic [2:0] PCS_T_FRC  = 3'h7;

  // unlock byte sequence
  localparam logic [7:0] PCS_KEY0 = 8'h59;
  localparam logic [7:0] PCS_KEY1 = 8'h16;
  localparam logic [7:0] PCS_KEY2 = 8'h88;

  // watchdog divided bus clock
  localparam int PCS_WDT_DIVIDE = 2048;

  typedef enum logic [3:0] {
    PCS_LOCKED = 4'b0001,
    PCS_KEY_A  = 4'b0010,
    PCS_KEY_B  = 4'b0100,
    PCS_OPEN   = 4'b1000
  } pcs_lock_state_t;

endpackage : pcs_pkg

// file: pcs_unlock.sv
/*
  Register protection lock: watches byte writes to the unlock address and
  opens after three correct bytes in a row.
  Assumes writes arrive as one-cycle strobes on the block clock.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_unlock
  import pcs_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // write to the unlock address
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  // protection state
  output logic            unlocked
);

  pcs_lock_state_t state_reg;
  pcs_lock_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (key_wr) begin
      case (state_reg)
        PCS_LOCKED: state_next = (key_data == PCS_KEY0) ? PCS_KEY_A
                                                         : PCS_LOCKED;
        PCS_KEY_A: begin
          if (key_data == PCS_KEY1) state_next = PCS_KEY_B;
          else if (key_data == PCS_KEY0) state_next = PCS_KEY_A;
          else state_next = PCS_LOCKED;
        end
        PCS_KEY_B: begin
          if (key_data == PCS_KEY2) state_next = PCS_OPEN;
          else if (key_data == PCS_KEY0) state_next = PCS_KEY_A;
          else state_next = PCS_LOCKED;
        end
        // any write to the unlock address while open closes the lock again
        PCS_OPEN: state_next = PCS_LOCKED;
        default:  state_next = PCS_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PCS_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign unlocked = (state_reg == PCS_OPEN);

endmodule : pcs_unlock

`default_nettype wire

// file: pcs_top.sv
/*
  Peripheral clock source selection: one selection register and one
  source multiplexer per peripheral (uart, four timers, serial
  peripheral interface, adc, watchdog), plus the protection lock.
  Assumes all source clocks arrive as levels synchronous to MCLK and
  that MCLK is the system bus clock used for the divided watchdog source.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module pcs_top
  import pcs_pkg::*;
#(
  parameter int WDT_DIVIDE = PCS_WDT_DIVIDE
)
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // register port
  input  wire logic [11:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // clock sources, as levels
  input  wire logic        CRYSTAL_OSC,
  input  wire logic        PLL_CLK,
  input  wire logic        SYS_BUS_CLK,
  input  wire logic [3:0]  TIMER_TRIG,
  input  wire logic        SLOW_RC_OSC,
  input  wire logic        FAST_RC_OSC,
  // selected peripheral clocks and protection flag
  output logic             UART_CLK,
  output logic      [3:0]  TIMER_CLK,
  output logic             SERIAL_PERIPH_CLK,
  output logic             ADC_CLK,
  output logic             WDT_CLK,
  output logic             PROTECT_OPEN
);

  localparam int HALF = WDT_DIVIDE / 2;
  localparam int CW   = $clog2(HALF);

  logic        rst_q1;
  logic        rst_n_sync;
  logic [31:0] peripheral_clock_select_reg;
  logic [31:0] rdata_reg;
  logic        unlocked;
  logic [CW-1:0] div_cnt_reg;
  logic        div_clk_reg;
  logic [2:0]  timer_clk_sel [4];

  // shared timer source decode; reserved codes give a quiet clock
  function automatic logic timer_mux(input logic [2:0] sel,
                                     input logic trig);
    case (sel)
      PCS_T_XTAL: timer_mux = CRYSTAL_OSC;
      PCS_T_BUS:  timer_mux = SYS_BUS_CLK;
      PCS_T_TRIG: timer_mux = trig;
      PCS_T_SRC:  timer_mux = SLOW_RC_OSC;
      PCS_T_FRC:  timer_mux = FAST_RC_OSC;
      default:    timer_mux = 1'b0;
    endcase
  endfunction : timer_mux

  // reset release through two flip-flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1     <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_q1     <= 1'b1;
      rst_n_sync <= rst_q1;
    end
  end

  pcs_unlock u_unlock (
    .clk      (MCLK),
    .rst_n    (rst_n_sync),
    .key_wr   (WR && (ADDR == PCS_ADDR_UNLOCK)),
    .key_data (WDATA[7:0]),
    .unlocked (unlocked)
  );

  // selection register; reserved bits hold their reset ones
  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      peripheral_clock_select_reg <= PCS_SEL_RESET;
    end else if (WR && (ADDR == PCS_ADDR_SEL)) begin
      for (int i = 0; i < 32; i++) begin
        if (PCS_FIELD_MASK[i] && (!PCS_WDT_MASK[i] || unlocked)) begin
          peripheral_clock_select_reg[i] <= WDATA[i];
        end
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rdata_reg <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        PCS_ADDR_SEL:    rdata_reg <= peripheral_clock_select_reg;
        PCS_ADDR_UNLOCK: rdata_reg <= {31'h0000_0000, unlocked};
        default:         rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // bus clock over WDT_DIVIDE: toggle every half period
  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      div_cnt_reg <= '0;
      div_clk_reg <= 1'b0;
    end else if (div_cnt_reg == CW'(HALF - 1)) begin
      div_cnt_reg <= '0;
      div_clk_reg <= ~div_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + CW'(1);
    end
  end

  assign timer_clk_sel[0] =
    peripheral_clock_select_reg[PCS_TMR0_LSB +: 3];
  assign timer_clk_sel[1] =
    peripheral_clock_select_reg[PCS_TMR1_LSB +: 3];
  assign timer_clk_sel[2] =
    peripheral_clock_select_reg[PCS_TMR2_LSB +: 3];
  assign timer_clk_sel[3] =
    peripheral_clock_select_reg[PCS_TMR3_LSB +: 3];

  // the glitch-free switch lives outside; software must keep both
  // the old and the new source running across a change
  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      TIMER_CLK <= 4'h0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        TIMER_CLK[t] <= timer_mux(timer_clk_sel[t], TIMER_TRIG[t]);
      end
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      UART_CLK <= 1'b0;
    end else begin
      case (peripheral_clock_select_reg[PCS_UART_LSB +: 2])
        PCS_S2_XTAL: UART_CLK <= CRYSTAL_OSC;
        PCS_S2_PLL:  UART_CLK <= PLL_CLK;
        PCS_S2_FRC:  UART_CLK <= FAST_RC_OSC;
        default:     UART_CLK <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      SERIAL_PERIPH_CLK <= 1'b0;
    end else begin
      SERIAL_PERIPH_CLK <= peripheral_clock_select_reg[PCS_SPI_BIT]
                           ? SYS_BUS_CLK : PLL_CLK;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ADC_CLK <= 1'b0;
    end else begin
      case (peripheral_clock_select_reg[PCS_ADC_LSB +: 2])
        PCS_S2_XTAL: ADC_CLK <= CRYSTAL_OSC;
        PCS_S2_PLL:  ADC_CLK <= PLL_CLK;
        PCS_S2_BUS:  ADC_CLK <= SYS_BUS_CLK;
        default:     ADC_CLK <= FAST_RC_OSC;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      WDT_CLK <= 1'b0;
    end else begin
      case (peripheral_clock_select_reg[PCS_WDT_LSB +: 2])
        PCS_WDT_DIV: WDT_CLK <= div_clk_reg;
        PCS_WDT_SRC: WDT_CLK <= SLOW_RC_OSC;
        default:     WDT_CLK <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      PROTECT_OPEN <= 1'b0;
    end else begin
      PROTECT_OPEN <= unlocked;
    end
  end

  assign RDATA = rdata_reg;

endmodule : pcs_top

`default_nettype wire

// file: pcs_top_asserts.sv
/* checker for pcs_top: readback, clock mux paths, protection flag.
   bound to pcs_top from the testbench top; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none

module pcs_top_asserts
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  // register port
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // sources
  input wire logic        CRYSTAL_OSC,
  input wire logic        PLL_CLK,
  input wire logic        SYS_BUS_CLK,
  input wire logic [3:0]  TIMER_TRIG,
  input wire logic        SLOW_RC_OSC,
  input wire logic        FAST_RC_OSC,
  // selected clocks and protection flag
  input wire logic        UART_CLK,
  input wire logic [3:0]  TIMER_CLK,
  input wire logic        SERIAL_PERIPH_CLK,
  input wire logic        ADC_CLK,
  input wire logic        PROTECT_OPEN
);
  // shadow of the select word; its watchdog bits are never used
  logic [31:0] sh_reg;
  logic [1:0]  up_reg;
  logic [3:0]  src4, e_tmr;
  logic        ok, e_uart, e_spi, e_adc, rd_sel, unl_wr, key_wr;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  function automatic logic t_mux(logic [2:0] c, logic g);
    case (c)
      PCS_T_XTAL: return CRYSTAL_OSC;
      PCS_T_BUS:  return SYS_BUS_CLK;
      PCS_T_TRIG: return g;
      PCS_T_SRC:  return SLOW_RC_OSC;
      PCS_T_FRC:  return FAST_RC_OSC;
      default:    return 1'b0;
    endcase
  endfunction : t_mux

  // clock outputs are checked only once the two-flop reset copy has let go
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_reg <= PCS_SEL_RESET;
      up_reg <= 2'h0;
    end else begin
      if (!ok) up_reg <= up_reg + 2'h1;
      if (WR && ADDR == PCS_ADDR_SEL) sh_reg <= WDATA;
    end
  end

  always_comb begin
    ok     = up_reg == 2'h3;
    src4   = {FAST_RC_OSC, SYS_BUS_CLK, PLL_CLK, CRYSTAL_OSC};
    e_uart = src4[sh_reg[25:24]] & (sh_reg[25:24] != PCS_S2_BUS);
    e_adc  = src4[sh_reg[3:2]];
    e_spi  = sh_reg[PCS_SPI_BIT] ? SYS_BUS_CLK : PLL_CLK;
    for (int t = 0; t < 4; t++) begin
      e_tmr[t] = t_mux(sh_reg[PCS_TMR0_LSB + 4 * t +: 3], TIMER_TRIG[t]);
    end
    rd_sel = RD && ADDR == PCS_ADDR_SEL;
    unl_wr = WR && ADDR == PCS_ADDR_UNLOCK;
    key_wr = unl_wr && WDATA[7:0] == PCS_KEY2;
  end

  property p_uart; ok |-> UART_CLK == $past(e_uart); endproperty
  a_uart: assert property (p_uart) else $error("uart clock");
  property p_tmr; ok |-> TIMER_CLK == $past(e_tmr); endproperty
  a_tmr: assert property (p_tmr) else $error("timer clk");
  property p_spi; ok |-> SERIAL_PERIPH_CLK == $past(e_spi); endproperty
  a_spi: assert property (p_spi) else $error("serial clock");
  property p_adc; ok |-> ADC_CLK == $past(e_adc); endproperty
  a_adc: assert property (p_adc) else $error("adc clock");
  property p_rsvd; $past(rd_sel) |-> (RDATA | PCS_FIELD_MASK) == '1;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_fld;
    $past(rd_sel) |->
      ((RDATA ^ $past(sh_reg)) & PCS_FIELD_MASK & ~PCS_WDT_MASK) == '0;
  endproperty
  a_fld: assert property (p_fld) else $error("field readback");
  property p_rise; $rose(PROTECT_OPEN) |-> $past(key_wr, 2); endproperty
  a_rise: assert property (p_rise) else $error("open without key");
  property p_fall; $fell(PROTECT_OPEN) |-> $past(unl_wr, 2); endproperty
  a_fall: assert property (p_fall) else $error("early relock");

  c_open: cover property (PROTECT_OPEN);
  c_trig: cover property (ok && TIMER_CLK == 4'hA);
  c_read: cover property (rd_sel);
endmodule : pcs_top_asserts
`default_nettype wire

// file: pcs_top_tb_top.sv
/* testbench for pcs_top: drives register port and source levels,
   checks readback and selected clocks. needs pcs_pkg and the checker. */
`timescale 1ns/10ps
`default_nettype none

module pcs_top_tb_top
  import pcs_pkg::*;
;
  localparam int          wdt_div  = 8;
  localparam logic [31:0] keep     = ~PCS_FIELD_MASK | PCS_WDT_MASK;
  localparam logic [31:0] word_tab [7] = '{32'h0000_0000, 32'h0100_0004,
    32'h0022_2218, 32'h0033_3300, 32'h0055_5500, 32'h0377_770C,
    32'h0211_4600};
  // crystal, pll, bus, slow rc, fast rc, trigger[3:0]
  localparam logic [8:0]  src_tab [7] = '{9'h100, 9'h080, 9'h040, 9'h00A,
    9'h020, 9'h010, 9'h1FF};
  // uart, timer[3:0], serial, adc, watchdog
  localparam logic [7:0]  clk_tab [7] = '{8'hFA, 8'h86, 8'h7E, 8'h50,
    8'h79, 8'hFA, 8'h07};
  logic        mclk  = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] addr  = '0;
  logic [31:0] wdata = '0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [8:0]  src   = '0;
  wire  [31:0] rdata;
  wire  [7:0]  clks;
  wire         prot_open;
  int          n_errors = 0;
  int          checked  = 0;

  always #4 mclk = ~mclk;

  pcs_top #(.WDT_DIVIDE(wdt_div)) i_dut (
    .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CRYSTAL_OSC(src[8]), .PLL_CLK(src[7]),
    .SYS_BUS_CLK(src[6]), .SLOW_RC_OSC(src[5]), .FAST_RC_OSC(src[4]),
    .TIMER_TRIG(src[3:0]), .UART_CLK(clks[7]), .TIMER_CLK(clks[6:3]),
    .SERIAL_PERIPH_CLK(clks[2]), .ADC_CLK(clks[1]), .WDT_CLK(clks[0]),
    .PROTECT_OPEN(prot_open));

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic keys(logic [23:0] k);
    for (int i = 2; i >= 0; i--) begin
      wr_reg(PCS_ADDR_UNLOCK, 32'(k[8 * i +: 8]));
    end
  endtask : keys

  task automatic stop_test();
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    int          n;
    logic        b;
    logic [31:0] v;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_reg(PCS_ADDR_SEL, v);
    chk("select reset", v, PCS_SEL_RESET);
    rd_reg(12'h008, v);
    chk("unmapped read", v, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      src <= src_tab[i];
      wr_reg(PCS_ADDR_SEL, word_tab[i]);
      repeat (3) @(posedge mclk);
      #1;
      chk("clocks", 32'(clks), 32'(clk_tab[i]));
      rd_reg(PCS_ADDR_SEL, v);
      chk("readback", v, word_tab[i] & PCS_FIELD_MASK | keep);
    end
    // a wrong middle byte must restart the sequence
    keys({PCS_KEY0, 8'h00, PCS_KEY2});
    repeat (2) @(posedge mclk);
    #1 chk("bad key", 32'(prot_open), 32'h0);
    keys({PCS_KEY0, PCS_KEY1, PCS_KEY2});
    rd_reg(PCS_ADDR_UNLOCK, v);
    chk("unlock bit", 32'(v[0]), 32'h1);
    chk("open flag", 32'(prot_open), 32'h1);
    src <= 9'h000;
    wr_reg(PCS_ADDR_SEL, 32'hFFFF_FFFE);
    repeat (4) @(posedge mclk);
    #1 b = clks[0];
    n = 0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      if (clks[0] !== b) n++;
      b = clks[0];
    end
    chk("divided toggles", 32'(n), 32'(8 / (wdt_div / 2)));
    wr_reg(PCS_ADDR_UNLOCK, 32'h0000_0000);
    wr_reg(PCS_ADDR_SEL, 32'hFFFF_FFFF);
    rd_reg(PCS_ADDR_SEL, v);
    chk("locked field", v, 32'hFFFF_FFFE);
    chk("closed flag", 32'(prot_open), 32'h0);
    stop_test();
  end

  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule : pcs_top_tb_top

bind pcs_top pcs_top_asserts i_chk (.MCLK, .RST_N, .ADDR, .WDATA, .WR,
  .RD, .RDATA, .CRYSTAL_OSC, .PLL_CLK, .SYS_BUS_CLK, .TIMER_TRIG,
  .SLOW_RC_OSC, .FAST_RC_OSC, .UART_CLK, .TIMER_CLK, .SERIAL_PERIPH_CLK,
  .ADC_CLK, .PROTECT_OPEN);
`default_nettype wire
